// ===== core/gpa_pad.sv
/*
 Output path of one pin: priority mux of port latch and two peripheral
 outputs, and the drive/enable split for push-pull or open-drain pads.
 Assumes the enable output is low while driving.
*/
`timescale 1ns/1ns
module gpa_pad #(
	parameter bit OPEN_DRAIN = 1'b0
) (
	input  wire logic latch,
	input  wire logic tris,
	input  wire logic en_lo,
	input  wire logic val_lo,
	input  wire logic en_hi,
	input  wire logic val_hi,
	output logic      pin_o,
	output logic      pin_oe_n
);
	logic v;
	always_comb begin
		if (en_hi) begin
			v = val_hi;
		end else if (en_lo) begin
			v = val_lo;
		end else begin
			v = latch;
		end
		// An open-drain pad only pulls low and floats for a one.
		pin_o = OPEN_DRAIN ? 1'b0 : v;
		pin_oe_n = OPEN_DRAIN ? (tris | v) : tris;
	end
endmodule

// ===== core/gpa_pkg.sv
/*
 Package for the general purpose port A block: widths, bit positions,
 reset values and the packed structs that carry register-write and peripheral groups.
 Assumes a single 20 MHz core clock and no register bus.
*/
package gpa_pkg;
	localparam int unsigned W = 8;
	localparam logic [7:0] IMPL_MASK    = 8'hef;
	localparam logic [7:0] TRIS_RST     = 8'hef;
	localparam logic [7:0] TRIS_FORCE   = 8'h20;
	localparam logic [7:0] WPU_MASK     = 8'h2f;
	localparam logic [7:0] WPU_RST      = 8'h2f;
	localparam logic [7:0] ANS_MASK     = 8'h0f;
	localparam logic [7:0] ANS_RST      = 8'h0f;
	localparam logic [7:0] IOC_MASK     = 8'hef;
	localparam logic [7:0] IOC_RST      = 8'h00;
	localparam logic [7:0] LATCH_RST    = 8'h00;
	localparam logic [7:0] OD_MASK      = 8'h80;
	localparam logic [7:0] IN_ONLY_MASK = 8'h20;
	localparam int unsigned IN_ONLY_BIT = 5;
	localparam logic       GPU_DIS_RST  = 1'b1;

	typedef struct packed {
		logic [7:0] wdata;
		logic [7:0] wmask;
		logic       wr;
	} gpa_wr_t;

	typedef struct packed {
		logic [7:0] en_lo;
		logic [7:0] val_lo;
		logic [7:0] en_hi;
		logic [7:0] val_hi;
	} gpa_periph_t;
endpackage

// ===== core/gpa_port.sv
/*
 General purpose port A: pin sampling, output latch with read-modify-write,
 direction, analog select, weak pull-ups, change-interrupt enables and
 peripheral takeover. Control bits are plain ports; pins are three signals.
 Assumes the pin inputs are synchronous to clk.
*/
//
// Summary of operation
// - Eight bits: five push-pull, one open-drain, one input-only, no bit four.
// - Direction one turns the driver off.
// - Direction zero drives latch or peripheral value.
// - Bit five always reads input direction.
// - Reads see pins; writes go to latch.
// - Writes are read-modify-write from pin values.
// - Direction still controls drivers on analog pins.
// - Digital output pins read back the actual level.
// - Analog select forces digital reads to zero.
// - Analog select leaves digital output untouched.
// - Analog select defaults to analog after reset.
// - Change enables per pin, cleared at reset.
// - Pull-ups only on pins three to zero, five.
// - Pull-up off when output or peripheral.
// - Global pull-up disable set at reset.
// - External reset mode forces pin five pull-up.
// - Enabled peripheral takes the pin from port.
// - Highest priority enabled output function wins.
// - Pull-up needs global, input, bit, digital.
// - Analog disables input buffer, pull-up, change.
// - Pin seven only pulls low.
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
module gpa_port (
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire gpa_pkg::gpa_wr_t    data_wr,
	input  wire gpa_pkg::gpa_wr_t    dir_wr,
	input  wire gpa_pkg::gpa_wr_t    pullup_wr,
	input  wire gpa_pkg::gpa_wr_t    analog_wr,
	input  wire gpa_pkg::gpa_wr_t    ioc_wr,
	input  wire logic                gpu_dis_wr,
	input  wire logic                gpu_dis_wdata,
	input  wire logic                ext_reset_mode,
	input  wire gpa_pkg::gpa_periph_t periph,
	input  wire logic [7:0]          pin_i,
	output logic      [7:0]          pin_o,
	output logic      [7:0]          pin_oe_n,
	output logic      [7:0]          pullup_on,
	output logic      [7:0]          port_a_pin_data,
	output logic      [7:0]          port_a_latch,
	output logic      [7:0]          port_a_direction,
	output logic      [7:0]          port_a_pullup_enable,
	output logic      [7:0]          port_a_analog_select,
	output logic      [7:0]          change_interrupt_enable,
	output logic      [7:0]          change_active,
	output logic                     global_pullup_disable
);
	logic [7:0] dig_in;
	logic [7:0] tris_q;
	logic [7:0] next_latch;
	logic [7:0] periph_own;

	////////////////////////////////////////////////////////////////////////
	// Configuration registers.
	gpa_reg #(.IMPL(gpa_pkg::IMPL_MASK & ~gpa_pkg::TRIS_FORCE), .RST(gpa_pkg::TRIS_RST)) u_dir (
		.clk   (clk),
		.rst_n (rst_n),
		.we    (dir_wr.wr),
		.wdata ((dir_wr.wdata & dir_wr.wmask) | (tris_q & ~dir_wr.wmask)),
		.q     (tris_q)
	);
	assign port_a_direction = tris_q | gpa_pkg::TRIS_FORCE;

	gpa_reg #(.IMPL(gpa_pkg::WPU_MASK), .RST(gpa_pkg::WPU_RST)) u_wpu (
		.clk   (clk),
		.rst_n (rst_n),
		.we    (pullup_wr.wr),
		.wdata ((pullup_wr.wdata & pullup_wr.wmask) | (port_a_pullup_enable & ~pullup_wr.wmask)),
		.q     (port_a_pullup_enable)
	);

	gpa_reg #(.IMPL(gpa_pkg::ANS_MASK), .RST(gpa_pkg::ANS_RST)) u_ans (
		.clk   (clk),
		.rst_n (rst_n),
		.we    (analog_wr.wr),
		.wdata ((analog_wr.wdata & analog_wr.wmask) | (port_a_analog_select & ~analog_wr.wmask)),
		.q     (port_a_analog_select)
	);

	gpa_reg #(.IMPL(gpa_pkg::IOC_MASK), .RST(gpa_pkg::IOC_RST)) u_ioc (
		.clk   (clk),
		.rst_n (rst_n),
		.we    (ioc_wr.wr),
		.wdata ((ioc_wr.wdata & ioc_wr.wmask) | (change_interrupt_enable & ~ioc_wr.wmask)),
		.q     (change_interrupt_enable)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			global_pullup_disable <= gpa_pkg::GPU_DIS_RST;
		end else if (gpu_dis_wr) begin
			global_pullup_disable <= gpu_dis_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pin sampling and output latch.
	// Analog pins lose their input buffer, so they read zero even when driven.
	assign dig_in = pin_i & ~port_a_analog_select & gpa_pkg::IMPL_MASK;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			port_a_pin_data <= 8'h00;
		end else begin
			port_a_pin_data <= dig_in;
		end
	end

	// Unwritten bits reload from the pins, so an analog output bit may clear.
	assign next_latch = ((data_wr.wdata & data_wr.wmask) | (port_a_pin_data & ~data_wr.wmask))
		& gpa_pkg::IMPL_MASK & ~gpa_pkg::IN_ONLY_MASK;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			port_a_latch <= gpa_pkg::LATCH_RST;
		end else if (data_wr.wr) begin
			port_a_latch <= next_latch;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pads, pull-ups and change enables per pin.
	assign periph_own = periph.en_lo | periph.en_hi;

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_pin
			if (i == 4) begin : g_none
				assign pin_o[i] = 1'b0;
				assign pin_oe_n[i] = 1'b1;
			end else if (i == gpa_pkg::IN_ONLY_BIT) begin : g_in
				assign pin_o[i] = 1'b0;
				assign pin_oe_n[i] = 1'b1;
			end else begin : g_io
				gpa_pad #(.OPEN_DRAIN(gpa_pkg::OD_MASK[i])) u_pad (
					.latch    (port_a_latch[i]),
					.tris     (tris_q[i]),
					.en_lo    (periph.en_lo[i]),
					.val_lo   (periph.val_lo[i]),
					.en_hi    (periph.en_hi[i]),
					.val_hi   (periph.val_hi[i]),
					.pin_o    (pin_o[i]),
					.pin_oe_n (pin_oe_n[i])
				);
			end
		end
	endgenerate

	always_comb begin
		// Replicated so that the one-bit disable masks all eight pins, not only bit zero.
		pullup_on = {8{~global_pullup_disable}} & port_a_direction & port_a_pullup_enable
			& ~port_a_analog_select & ~periph_own & gpa_pkg::WPU_MASK;
		if (ext_reset_mode) begin
			pullup_on[gpa_pkg::IN_ONLY_BIT] = 1'b1;
		end
	end

	assign change_active = change_interrupt_enable & ~port_a_analog_select;

	////////////////////////////////////////////////////////////////////////
	// Checks.
	property p_in_only;
		@(posedge clk) disable iff (!rst_n) port_a_direction[5] && pin_oe_n[5];
	endproperty
	a_in_only: assert property (p_in_only) else $error("Input-only pin drives or reads as output.");

	property p_analog_read;
		@(posedge clk) disable iff (!rst_n) port_a_analog_select[0] |=> !port_a_pin_data[0];
	endproperty
	a_analog_read: assert property (p_analog_read) else $error("Analog pin read non-zero.");

	property p_od_high;
		@(posedge clk) disable iff (!rst_n) !pin_oe_n[7] |-> !pin_o[7];
	endproperty
	a_od_high: assert property (p_od_high) else $error("Open-drain pin driven high.");

	property p_tris_off;
		@(posedge clk) disable iff (!rst_n) tris_q[0] |-> pin_oe_n[0];
	endproperty
	a_tris_off: assert property (p_tris_off) else $error("Input pin is driven.");

	property p_drive;
		@(posedge clk) disable iff (!rst_n) (!tris_q[1] && !periph_own[1]) |-> (!pin_oe_n[1] && pin_o[1] == port_a_latch[1]);
	endproperty
	a_drive: assert property (p_drive) else $error("Output pin not driving latch.");

	property p_pullup_out;
		@(posedge clk) disable iff (!rst_n) (!port_a_direction[0] || periph_own[0]) |-> !pullup_on[0];
	endproperty
	a_pullup_out: assert property (p_pullup_out) else $error("Pull-up on for output pin.");

	property p_ext_reset_pu;
		@(posedge clk) disable iff (!rst_n) ext_reset_mode |-> pullup_on[5];
	endproperty
	a_ext_reset_pu: assert property (p_ext_reset_pu) else $error("External reset pull-up missing.");

	property p_rmw;
		@(posedge clk) disable iff (!rst_n) (data_wr.wr && !data_wr.wmask[2]) |=> port_a_latch[2] == $past(port_a_pin_data[2]);
	endproperty
	a_rmw: assert property (p_rmw) else $error("Unwritten latch bit not taken from pins.");

	property p_bit4;
		@(posedge clk) disable iff (!rst_n) !port_a_pin_data[4] && !port_a_direction[4] && !change_interrupt_enable[4];
	endproperty
	a_bit4: assert property (p_bit4) else $error("Bit four not zero.");

	property p_no_pu76;
		@(posedge clk) disable iff (!rst_n) pullup_on[7:6] == 2'b00;
	endproperty
	a_no_pu76: assert property (p_no_pu76) else $error("Pull-up on pin seven or six.");

	////////////////////////////////////////////////////////////////////////
	// Write and reset steps that the checks below start from.
	sequence s_reset_done;
		$rose(rst_n);
	endsequence

	sequence s_dir_out0;
		dir_wr.wr && dir_wr.wmask[0] && !dir_wr.wdata[0];
	endsequence

	sequence s_dir_in0;
		dir_wr.wr && dir_wr.wmask[0] && dir_wr.wdata[0];
	endsequence

	// A second analog write right behind the first could undo it, so the check waits for a quiet cycle.
	sequence s_analog_on0;
		analog_wr.wr && analog_wr.wmask[0] && analog_wr.wdata[0] ##1 !analog_wr.wr;
	endsequence

	property p_reset_values;
		@(posedge clk) disable iff (!rst_n) s_reset_done |-> (port_a_analog_select == gpa_pkg::ANS_RST
			&& change_interrupt_enable == gpa_pkg::IOC_RST && global_pullup_disable == gpa_pkg::GPU_DIS_RST);
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("Reset value missing.");

	property p_no_drive4;
		@(posedge clk) disable iff (!rst_n) pin_oe_n[4] && !pin_o[4];
	endproperty
	a_no_drive4: assert property (p_no_drive4) else $error("Missing pin four is driven.");

	property p_dir_out;
		@(posedge clk) disable iff (!rst_n) s_dir_out0 |=> !port_a_direction[0];
	endproperty
	a_dir_out: assert property (p_dir_out) else $error("Direction zero not taken.");

	property p_dir_in;
		@(posedge clk) disable iff (!rst_n) s_dir_in0 |=> port_a_direction[0];
	endproperty
	a_dir_in: assert property (p_dir_in) else $error("Direction one not taken.");

	property p_dir5_fixed;
		@(posedge clk) disable iff (!rst_n) (dir_wr.wr && !dir_wr.wdata[5]) |=> port_a_direction[5];
	endproperty
	a_dir5_fixed: assert property (p_dir5_fixed) else $error("Input-only direction bit cleared.");

	property p_pin_sample;
		@(posedge clk) disable iff (!rst_n) !port_a_analog_select[1] |=> port_a_pin_data[1] == $past(pin_i[1]);
	endproperty
	a_pin_sample: assert property (p_pin_sample) else $error("Pin data does not follow the pin.");

	property p_analog_write;
		@(posedge clk) disable iff (!rst_n) s_analog_on0 |=> !port_a_pin_data[0];
	endproperty
	a_analog_write: assert property (p_analog_write) else $error("Pin read after analog select not zero.");

	property p_latch_hold;
		@(posedge clk) disable iff (!rst_n) !data_wr.wr |=> $stable(port_a_latch);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("Latch moved without a write.");

	property p_latch_write;
		@(posedge clk) disable iff (!rst_n) (data_wr.wr && data_wr.wmask[3]) |=> port_a_latch[3] == $past(data_wr.wdata[3]);
	endproperty
	a_latch_write: assert property (p_latch_write) else $error("Written latch bit not taken.");

	property p_latch_unused;
		@(posedge clk) disable iff (!rst_n) port_a_latch[5:4] == 2'b00;
	endproperty
	a_latch_unused: assert property (p_latch_unused) else $error("Latch bit five or four set.");

	property p_analog_out;
		@(posedge clk) disable iff (!rst_n) (!tris_q[0] && !periph_own[0] && port_a_analog_select[0])
			|-> (!pin_oe_n[0] && pin_o[0] == port_a_latch[0]);
	endproperty
	a_analog_out: assert property (p_analog_out) else $error("Analog pin stopped driving.");

	property p_periph_hi;
		@(posedge clk) disable iff (!rst_n) (periph.en_hi[6] && !tris_q[6])
			|-> (!pin_oe_n[6] && pin_o[6] == periph.val_hi[6]);
	endproperty
	a_periph_hi: assert property (p_periph_hi) else $error("Higher function does not own the pin.");

	property p_periph_lo;
		@(posedge clk) disable iff (!rst_n) (periph.en_lo[6] && !periph.en_hi[6] && !tris_q[6])
			|-> (!pin_oe_n[6] && pin_o[6] == periph.val_lo[6]);
	endproperty
	a_periph_lo: assert property (p_periph_lo) else $error("Peripheral does not own the pin.");

	property p_od_float;
		@(posedge clk) disable iff (!rst_n) (!tris_q[7] && port_a_latch[7] && !periph_own[7]) |-> pin_oe_n[7];
	endproperty
	a_od_float: assert property (p_od_float) else $error("Open-drain pin not released for a one.");

	property p_pu_global;
		@(posedge clk) disable iff (!rst_n) (global_pullup_disable && !ext_reset_mode) |-> pullup_on == 8'h00;
	endproperty
	a_pu_global: assert property (p_pu_global) else $error("Pull-up on while globally disabled.");

	property p_pu_analog;
		@(posedge clk) disable iff (!rst_n) port_a_analog_select[0] |-> !pullup_on[0];
	endproperty
	a_pu_analog: assert property (p_pu_analog) else $error("Pull-up on for analog pin.");

	property p_pu_bit;
		@(posedge clk) disable iff (!rst_n) !port_a_pullup_enable[2] |-> !pullup_on[2];
	endproperty
	a_pu_bit: assert property (p_pu_bit) else $error("Pull-up on without its enable bit.");

	property p_pu_on;
		@(posedge clk) disable iff (!rst_n) (!global_pullup_disable && port_a_direction[3] && port_a_pullup_enable[3]
			&& !port_a_analog_select[3] && !periph_own[3]) |-> pullup_on[3];
	endproperty
	a_pu_on: assert property (p_pu_on) else $error("Pull-up missing on digital input.");

	property p_change_gate;
		@(posedge clk) disable iff (!rst_n) port_a_analog_select[0] |-> !change_active[0];
	endproperty
	a_change_gate: assert property (p_change_gate) else $error("Change enable active on analog pin.");

	property p_change_on;
		@(posedge clk) disable iff (!rst_n) change_interrupt_enable[6] |-> change_active[6];
	endproperty
	a_change_on: assert property (p_change_on) else $error("Change enable lost on digital pin.");

	property p_gpd_write;
		@(posedge clk) disable iff (!rst_n) gpu_dis_wr |=> global_pullup_disable == $past(gpu_dis_wdata);
	endproperty
	a_gpd_write: assert property (p_gpd_write) else $error("Global pull-up disable not written.");

	property p_ioc_write;
		@(posedge clk) disable iff (!rst_n) (ioc_wr.wr && ioc_wr.wmask[7]) |=> change_interrupt_enable[7] == $past(ioc_wr.wdata[7]);
	endproperty
	a_ioc_write: assert property (p_ioc_write) else $error("Change enable not written.");

	property p_pue_unused;
		@(posedge clk) disable iff (!rst_n) port_a_pullup_enable[7:6] == 2'b00 && !port_a_pullup_enable[4];
	endproperty
	a_pue_unused: assert property (p_pue_unused) else $error("Pull-up bit set on a pin without one.");
endmodule

// ===== core/gpa_reg.sv
/*
 Generic masked register: holds the implemented bits, resets to a constant,
 takes whole-byte writes; the caller merges in the per-bit write mask.
 Assumes synchronous active-low reset.
*/
`timescale 1ns/1ns
module gpa_reg #(
	parameter logic [7:0] IMPL = 8'hff,
	parameter logic [7:0] RST  = 8'h00
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       we,
	input  wire logic [7:0] wdata,
	output logic      [7:0] q
);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= RST & IMPL;
		end else if (we) begin
			q <= wdata & IMPL;
		end
	end
endmodule

// ===== verif/gpa_board.sv
/*
 Board model for the port A pins: resolves each pin from the device driver,
 an external driver and the weak pull-up.
 Assumes the bench sets the external drivers.
*/
`timescale 1ns/1ns
module gpa_board (
	input  wire logic       clk,
	input  wire logic [7:0] pin_o,
	input  wire logic [7:0] pin_oe_n,
	input  wire logic [7:0] pullup_on,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext_val,
	output logic      [7:0] pin_i
);
////////////////////////////////////////////////////////////////////////////////
	logic [7:0] flt = 8'h55;
	// A floating pin wanders, so no check may rely on its level.
	always @(negedge clk) flt <= ~flt;
	always_comb begin
		for (int b = 0; b < 8; b++) begin
			pin_i[b] = !pin_oe_n[b] ? pin_o[b] : ext_en[b] ? ext_val[b] : pullup_on[b] ? 1'b1 : flt[b];
		end
	end
endmodule

// ===== verif/tb_top.sv
/*
 Self-checking bench for port A: register writes through the write strobes,
 pin levels from the board model.
 Assumes one 20 MHz clock and the board model beside the port.
*/
`timescale 1ns/1ns
module tb_top;
	logic                 clk = 1'b0;
	logic                 rst_n = 1'b0;
	gpa_pkg::gpa_wr_t     w[5];
	logic                 gwr = 1'b0;
	logic                 gwd = 1'b1;
	logic                 xrm = 1'b0;
	gpa_pkg::gpa_periph_t per = '0;
	logic [7:0]           ext_en = 8'ha0;
	logic [7:0]           ext_val = 8'ha0;
	logic [7:0]           pin_i, pin_o, oe_n, pu, pd, lat, dir, pue, ans, ioc, cha;
	logic                 gpd;
	int                   num_errors = 0;
	int                   n_tests = 0;
	initial for (int k = 0; k < 5; k++) w[k] = '0;
	initial forever #25 clk = ~clk;
	gpa_port i_gpa_port (.clk(clk), .rst_n(rst_n), .data_wr(w[0]), .dir_wr(w[1]), .pullup_wr(w[2]),
		.analog_wr(w[3]), .ioc_wr(w[4]), .gpu_dis_wr(gwr), .gpu_dis_wdata(gwd), .ext_reset_mode(xrm),
		.periph(per), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(oe_n), .pullup_on(pu), .port_a_pin_data(pd),
		.port_a_latch(lat), .port_a_direction(dir), .port_a_pullup_enable(pue),
		.port_a_analog_select(ans), .change_interrupt_enable(ioc), .change_active(cha),
		.global_pullup_disable(gpd));
	gpa_board i_gpa_board (.clk(clk), .pin_o(pin_o), .pin_oe_n(oe_n), .pullup_on(pu), .ext_en(ext_en),
		.ext_val(ext_val), .pin_i(pin_i));
////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Each strobe lasts one cycle; the task returns once the register shows it.
	task automatic wr(input int k, input logic [7:0] d, input logic [7:0] m);
		@(negedge clk);
		w[k] = '{wdata: d, wmask: m, wr: 1'b1};
		@(negedge clk);
		w[k].wr = 1'b0;
	endtask
	task automatic gw(input logic v);
		@(negedge clk);
		gwr = 1'b1;
		gwd = v;
		@(negedge clk);
		gwr = 1'b0;
	endtask
	task automatic idle2;
		@(negedge clk);
		@(negedge clk);
	endtask
	task automatic close_out;
		$display("Checks %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(3000 * 50);
		num_errors++;
		close_out();
	end
	initial begin
		repeat (4) @(negedge clk);
		chk("latch", lat, 8'h00);
		chk("dir", dir, 8'hef);
		chk("pue", pue, 8'h2f);
		chk("ans", ans, 8'h0f);
		chk("ioc", ioc, 8'h00);
		chk("gpd", {7'h00, gpd}, 8'h01);
		chk("oe_n", oe_n, 8'hff);
		chk("pu", pu, 8'h00);
		chk("pd", pd, 8'h00);
		rst_n = 1'b1;
		wr(3, 8'h00, 8'hff);
		wr(4, 8'hff, 8'hff);
		chk("ioc", ioc, 8'hef);
		chk("cha", cha, 8'hef);
		wr(1, 8'h00, 8'hff);
		chk("dir", dir, 8'h20);
		wr(2, 8'hff, 8'hff);
		chk("pue", pue, 8'h2f);
		wr(0, 8'hff, 8'hff);
		chk("latch", lat, 8'hcf);
		chk("oe_n", oe_n, 8'hb0);
		chk("drive", pin_o & 8'h4f, 8'h4f);
		idle2();
		chk("pd", pd, 8'hef);
		wr(0, 8'h7f, 8'h80);
		chk("latch", lat, 8'h4f);
		chk("oe_n", oe_n, 8'h30);
		chk("od", {7'h00, pin_o[7]}, 8'h00);
		wr(1, 8'h01, 8'h01);
		ext_en = 8'ha1;
		idle2();
		chk("pd", pd, 8'h6e);
		wr(0, 8'h00, 8'h02);
		chk("latch", lat, 8'h4c);
		wr(1, 8'h00, 8'h01);
		wr(0, 8'h01, 8'h01);
		wr(3, 8'h01, 8'hff);
		idle2();
		chk("pd", pd, 8'h6c);
		chk("oe_n", oe_n, 8'h30);
		chk("drv0", {7'h00, pin_o[0]}, 8'h01);
		chk("cha", cha, 8'hee);
		wr(1, 8'hff, 8'hff);
		chk("oe_n", oe_n, 8'hff);
		ext_en = 8'h00;
		gw(1'b0);
		chk("pu", pu, 8'h2e);
		wr(1, 8'h00, 8'h02);
		chk("pu", pu, 8'h2c);
		per.en_lo = 8'h04;
		@(negedge clk);
		chk("pu", pu, 8'h28);
		xrm = 1'b1;
		wr(2, 8'h00, 8'hff);
		gw(1'b1);
		chk("pu", pu, 8'h20);
		xrm = 1'b0;
		@(negedge clk);
		chk("pu", pu, 8'h00);
		wr(1, 8'h00, 8'hff);
		per.en_lo = 8'h40;
		@(negedge clk);
		chk("p6", {7'h00, pin_o[6]}, 8'h00);
		per.en_hi = 8'h40;
		per.val_hi = 8'h40;
		@(negedge clk);
		chk("p6", {7'h00, pin_o[6]}, 8'h01);
		// The low function and the latch both want a one, so only the high function can pull it to zero.
		per.val_hi = 8'h00;
		per.val_lo = 8'h40;
		@(negedge clk);
		chk("p6", {7'h00, pin_o[6]}, 8'h00);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		chk("latch", lat, 8'h00);
		chk("dir", dir, 8'hef);
		chk("ans", ans, 8'h0f);
		chk("ioc", ioc, 8'h00);
		chk("gpd", {7'h00, gpd}, 8'h01);
		chk("pu", pu, 8'h00);
		chk("oe_n", oe_n, 8'hff);
		wr(0, 8'h80, 8'hff);
		chk("latch", lat, 8'h80);
		close_out();
	end
endmodule
